/* verification/dma_completion_tcb_loader_assertions.sv */
/* checker for the dma channel ports.
   assumes control writes at index 0 mirror the channel's own control. */
`timescale 1ns/1ps
`default_nettype none
`include "dma_completion_map.svh"
module dma_completion_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_emu_halt,
    input wire logic i_xfer_req,
    input wire logic i_mem_busy,
    input wire logic i_bkpt_en,
    input wire logic [31:0] i_bkpt_addr,
    input wire logic [31:0] o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic o_bus_lock_periph,
    input wire logic o_bus_lock_ext,
    input wire logic o_xfer_ack,
    input wire logic o_bkpt_hit
);
    logic [7:0] ctrl_reg, ctrl_next;
    logic [5:0] lock_reg, lock_next, lock_exp;
    logic lock;
    assign lock = o_bus_lock_periph | o_bus_lock_ext;
    always_comb
    begin
        ctrl_next = (i_wr && i_addr == `REG_CTRL) ? i_wdata[7:0] : ctrl_reg;
        lock_next = lock ? lock_reg + 6'h01 : 6'h00;
        case (ctrl_reg[6:4])
            3'h0: lock_exp = `TCB_CYCLES_SERIAL;
            3'h1: lock_exp = `TCB_CYCLES_STD;
            3'h2: lock_exp = `TCB_CYCLES_CIRC;
            3'h3: lock_exp = `TCB_CYCLES_SG;
            default: lock_exp = `TCB_CYCLES_CIRC_SG;
        endcase
    end
    always_ff @(posedge i_clk)
    begin
        ctrl_reg <= i_srst ? 8'h00 : ctrl_next;
        lock_reg <= i_srst ? 6'h00 : lock_next;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence load_rise;
        $rose(lock);
    endsequence
    lock_len_a: assert property ($fell(lock) |-> lock_reg == lock_exp)
        else $error("descriptor load length wrong");
    bus_sel_a: assert property (lock |-> o_bus_lock_ext == ctrl_reg[1] && o_bus_lock_periph != ctrl_reg[1])
        else $error("wrong bus locked");
    lock_hold_a: assert property (load_rise |-> (lock && !o_xfer_ack) [*8])
        else $error("transfer inside descriptor load");
    ack_cause_a: assert property (o_xfer_ack |-> i_xfer_req && !i_mem_busy && !lock)
        else $error("word moved without request");
    halt_stop_a: assert property (i_emu_halt && $past(i_emu_halt) && ctrl_reg[3] |-> !o_xfer_ack)
        else $error("word moved while halted");
    rd_space_a: assert property (o_mem_rd && !lock |=> !(o_mem_rd && !lock))
        else $error("reads closer than two clocks");
    dir_word_a: assert property (o_xfer_ack |-> (ctrl_reg[2] ? !o_mem_rd : o_mem_rd))
        else $error("word access in wrong direction");
    bkpt_match_a: assert property (o_bkpt_hit |-> i_bkpt_en && o_mem_addr == i_bkpt_addr)
        else $error("breakpoint without address match");
endmodule : dma_completion_checker
bind dma_completion_tcb_loader dma_completion_checker chk (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_emu_halt(i_emu_halt), .i_xfer_req(i_xfer_req), .i_mem_busy(i_mem_busy),
    .i_bkpt_en(i_bkpt_en), .i_bkpt_addr(i_bkpt_addr), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_bus_lock_periph(o_bus_lock_periph), .o_bus_lock_ext(o_bus_lock_ext), .o_xfer_ack(o_xfer_ack),
    .o_bkpt_hit(o_bkpt_hit));
`default_nettype wire

/* verification/dma_memory_model.sv */
/* internal memory model: descriptor words and random stalls.
   assumes descriptors sit on 16-word boundaries. */
`timescale 1ns/1ps
`default_nettype none
module dma_memory_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_slow,
    input wire logic [31:0] i_mem_addr,
    input wire logic i_mem_rd,
    output logic [31:0] o_mem_rdata,
    output logic o_busy
);
    logic [31:0] word;
    always_comb
    begin
        case (i_mem_addr[3:0])
            4'h0: word = 32'h00000100;
            4'h1: word = 32'h00000001;
            4'h2: word = 32'h00000002;
            default: word = 32'h00000000;
        endcase
    end
    // data not held beyond its cycle, so a late capture sees garbage
    always_ff @(posedge i_clk)
    begin
        o_busy <= i_slow && ($urandom % 4 == 0);
        if (i_srst)
            o_mem_rdata <= 32'h5a5a5a5a;
        else
            o_mem_rdata <= i_mem_rd ? word : ~o_mem_rdata;
    end
endmodule : dma_memory_model
`default_nettype wire

/* verification/tb_dma_completion_tcb_loader.sv */
/* bench for the dma channel: bus tasks, integer model, scenarios.
   assumes the memory model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "dma_completion_map.svh"
module tb_dma_completion_tcb_loader;
    logic i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, slow = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, o_mem_addr, o_mem_wdata, mem_rdata;
    logic i_xfer_req = 1'b0, i_ext_pending = 1'b0, i_rx_avail = 1'b0, i_tx_room = 1'b0, i_emu_halt = 1'b0;
    logic i_bkpt_en = 1'b1, o_mem_rd, o_mem_wr, busy, lk_p, lk_e, ack, hit;
    logic [1:0] slot, latch_m, mask_m, prio_m = 2'h2, lm;
    int acks = 0, wrs = 0, lock_cyc, lock_rds, hits = 0, bad_count = 0, check_count = 0, n, a;
    int cyc_t[5] = '{26, 34, 40, 42, 50};
    int words_t[5] = '{4, 6, 7, 8, 10};
    always #5 i_clk = ~i_clk;
    dma_completion_tcb_loader dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
        .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(mem_rdata), .i_xfer_req(i_xfer_req),
        .i_mem_busy(busy), .i_ext_pending(i_ext_pending), .i_rx_avail(i_rx_avail), .i_tx_room(i_tx_room),
        .i_emu_halt(i_emu_halt), .i_bkpt_addr(32'h00000100), .i_bkpt_en(i_bkpt_en),
        .o_bus_lock_periph(lk_p), .o_bus_lock_ext(lk_e), .o_xfer_ack(ack), .o_bkpt_hit(hit), .o_irq_slot(slot));
    dma_memory_model mem (.i_clk(i_clk), .i_srst(i_srst), .i_slow(slow), .i_mem_addr(o_mem_addr),
        .i_mem_rd(o_mem_rd), .o_mem_rdata(mem_rdata), .o_busy(busy));
    // sampled mid-cycle so combinational pulses have settled
    always @(negedge i_clk)
    begin
        acks += ack;
        wrs += o_mem_wr;
        lock_cyc += (lk_p | lk_e);
        lock_rds += (o_mem_rd & (lk_p | lk_e));
        hits += hit;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] ad, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd
    task slot_chk;
        lm = latch_m & mask_m;
        #1 chk({30'h0, slot}, {30'h0, lm[prio_m[1]], lm[prio_m[0]]});
    endtask : slot_chk
    task wait_acks(input int k);
        for (int i = 0; i < 400 && acks < k; i++)
            @(posedge i_clk);
    endtask : wait_acks
    task start(input int cnt, input logic [31:0] ctl);
        wr(`REG_CTRL, 32'h0);
        wr(`REG_CHAIN, 32'h0);
        wr(`REG_LATCH, 32'h3);
        wr(`REG_MASK, 32'h0);
        mask_m = 2'h0;
        wr(`REG_INDEX, 32'h100);
        wr(`REG_MODIFIER, 32'h1);
        wr(`REG_COUNT, cnt);
        acks = 0;
        wrs = 0;
        wr(`REG_CTRL, ctl);
    endtask : start
    task finish_test;
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial
    begin
        #300000;
        bad_count++;
        finish_test();
    end
    initial
    begin
        void'($urandom(25039));
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(`REG_CTRL, 32'h0);
        rd(`REG_LATCH, 32'h0);
        rd(`REG_PRIO, `PRIO_RESET);
        wr(4'hf, 32'hffffffff);
        rd(4'hf, 32'h0);
        // unchained, write then read direction, external completion held back
        for (int dir = 0; dir < 2; dir++)
        begin
            n = $urandom_range(6, 2);
            slow <= 1'b1;
            i_ext_pending <= 1'b1;
            i_xfer_req <= 1'b1;
            start(n, 32'h3 | (dir ? 32'h0 : 32'h4));
            wait_acks(n);
            repeat (6) @(posedge i_clk);
            chk(acks, n);
            chk(wrs, dir ? 0 : n);
            rd(`REG_LATCH, 32'h0);
            i_ext_pending <= 1'b0;
            repeat (12) @(posedge i_clk);
            rd(`REG_LATCH, 32'h1);
            rd(`REG_COUNT, 32'h0);
            latch_m = 2'h1;
            slot_chk();
            wr(`REG_MASK, 32'h3);
            mask_m = 2'h3;
            slot_chk();
            prio_m = dir ? 2'h2 : 2'h1;
            wr(`REG_PRIO, prio_m);
            slot_chk();
            wr(`REG_LATCH, 32'h3);
            latch_m = 2'h0;
            slot_chk();
        end
        chk(hits != 0, 1);
        i_bkpt_en <= 1'b0;
        n = hits;
        // early stop by count write: zero gives silence, one gives a last word
        for (int k = 0; k < 2; k++)
        begin
            start(20, 32'h5);
            wait_acks(2);
            i_xfer_req <= 1'b0;
            wr(`REG_COUNT, k);
            a = acks;
            i_xfer_req <= 1'b1;
            repeat (20) @(posedge i_clk);
            chk(acks - a, k);
            rd(`REG_LATCH, k);
        end
        chk(hits, n);
        i_bkpt_en <= 1'b1;
        i_emu_halt <= 1'b1;
        start(3, 32'hd);
        repeat (10) @(posedge i_clk);
        chk(acks, 0);
        i_emu_halt <= 1'b0;
        wait_acks(3);
        chk(acks, 3);
        // chained loads of every descriptor type
        for (int t = 0; t < 5; t++)
        begin
            i_xfer_req <= 1'b0;
            wr(`REG_CTRL, 32'h0);
            wr(`REG_LATCH, 32'h3);
            wr(`REG_CTRL, (t << 4) | (t != 0 ? 32'h2 : 32'h0));
            lock_cyc = 0;
            lock_rds = 0;
            wr(`REG_CHAIN, 32'h40);
            repeat (60) @(posedge i_clk);
            chk(lock_cyc, cyc_t[t]);
            chk(lock_rds, words_t[t]);
            i_xfer_req <= 1'b1;
            acks = 0;
            if (t == 0)
            begin
                wait_acks(2);
                repeat (6) @(posedge i_clk);
                rd(`REG_LATCH, 32'h1);
            end
            else
                wr(`REG_COUNT, 32'h0);
        end
        // core single-word interrupts while idle
        wr(`REG_CTRL, 32'h80);
        for (int s = 0; s < 2; s++)
        begin
            wr(`REG_LATCH, 32'h3);
            i_rx_avail <= (s == 0);
            i_tx_room <= (s == 1);
            repeat (3) @(posedge i_clk);
            i_rx_avail <= 1'b0;
            i_tx_room <= 1'b0;
            rd(`REG_LATCH, 32'h2);
        end
        finish_test();
    end
endmodule : tb_dma_completion_tcb_loader
`default_nettype wire

/* verilog/dma_completion_map.svh */
/*
 * constants for the dma completion / descriptor loader: register offsets,
 * field positions, reset values and descriptor load figures.
 * assumes inclusion by bare name from the design and its package users.
 */
`ifndef DMA_COMPLETION_MAP_SVH
`define DMA_COMPLETION_MAP_SVH

// register indices on the plain software port
`define REG_CTRL 4'h0
`define REG_COUNT 4'h1
`define REG_INDEX 4'h2
`define REG_MODIFIER 4'h3
`define REG_CHAIN 4'h4
`define REG_STATUS 4'h5
`define REG_LATCH 4'h6
`define REG_MASK 4'h7
`define REG_PRIO 4'h8

// control fields
`define CTRL_ENABLE 0
`define CTRL_EXTERNAL 1
`define CTRL_EXT_WRITE 2
`define CTRL_HALT_STOP 3
`define CTRL_TYPE_LSB 4
`define CTRL_TYPE_MSB 6
`define CTRL_CORE_IRQ 7
`define CTRL_RESET 8'h00

// chain pointer: per-descriptor interrupt bit
`define CHAIN_PCI 19

// latch / mask bits
`define IRQ_DONE 0
`define IRQ_CORE 1

// interrupt slot assignment reset value: slot0=done, slot1=core
`define PRIO_RESET 2'h2

// descriptor sizes (words) and load cost (core cycles)
`define TCB_WORDS_SERIAL 4'h4
`define TCB_CYCLES_SERIAL 6'h1a
`define TCB_WORDS_STD 4'h6
`define TCB_CYCLES_STD 6'h22
`define TCB_WORDS_CIRC 4'h7
`define TCB_CYCLES_CIRC 6'h28
`define TCB_WORDS_SG 4'h8
`define TCB_CYCLES_SG 6'h2a
`define TCB_WORDS_CIRC_SG 4'ha
`define TCB_CYCLES_CIRC_SG 6'h32

`endif

/* verilog/dma_completion_pkg.sv */
/*
 * types for the dma completion / descriptor loader.
 * assumes nothing beyond a sv-2012 compiler.
 */
package dma_completion_pkg;
    typedef enum logic [2:0] {
        TCB_SERIAL,
        TCB_STD,
        TCB_CIRC,
        TCB_SG,
        TCB_CIRC_SG
    } tcb_type_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_RUN,
        ST_DRAIN
    } chan_state_t;
endpackage : dma_completion_pkg

/* verilog/dma_completion_tcb_loader.sv */
/*
 * one dma channel: count/index/modifier, chained descriptor loading with
 * bus lock, completion latching with mask, core single-word interrupts,
 * interrupt slot reassignment, emulation halt and debug address match.
 * assumes a peripheral clock core; memory side answers reads in 1 cycle
 * pairs (read strobe every other cycle) and accepts writes each cycle.
 */
// Function
// - completion only when moved words empty count
// - software zero write raises no interrupt
// - writing one moves one word, then interrupts
// - external write done after external writes finish
// - external read done after internal writes finish
// - core interrupt on rx data or tx room
// - software reassigns interrupt priority slots
// - emulation halt stops dma if selected
// - breakpoint on dma address bus
// - descriptor fetch holds dma bus locked
// - serial descriptor: four words, 26 cycles
// - standard/delay read: six words, 34 cycles
// - circular/delay write: seven words, 40 cycles
// - scatter/gather: eight words, 42 cycles
// - circular scatter/gather: ten words, 50 cycles
// - write per clock, read per two clocks
// - pci bit: interrupt per descriptor else chain end
// - masked interrupt latched but not signalled
`timescale 1ns/1ps
`default_nettype none
`include "dma_completion_map.svh"

module dma_completion_tcb_loader (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [31:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [31:0] o_mem_wdata,
    input wire logic [31:0] i_mem_rdata,
    input wire logic i_xfer_req,
    input wire logic i_mem_busy,
    input wire logic i_ext_pending,
    input wire logic i_rx_avail,
    input wire logic i_tx_room,
    input wire logic i_emu_halt,
    input wire logic [31:0] i_bkpt_addr,
    input wire logic i_bkpt_en,
    output logic o_bus_lock_periph,
    output logic o_bus_lock_ext,
    output logic o_xfer_ack,
    output logic o_bkpt_hit,
    output logic [1:0] o_irq_slot
);
    dma_completion_pkg::chan_state_t state_reg, state_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [31:0] count_reg, count_next;
    logic [31:0] index_reg, index_next;
    logic [31:0] mod_reg, mod_next;
    logic [31:0] chain_reg, chain_next;
    logic [1:0] latch_reg, latch_next;
    logic [1:0] mask_reg, mask_next;
    logic [1:0] prio_reg, prio_next;
    logic [5:0] lcyc_reg, lcyc_next;
    logic [3:0] lword_reg, lword_next;
    logic phase_reg, phase_next;
    // descriptor base kept apart: word 0 of a descriptor overwrites the index
    logic [18:0] tcb_ptr_reg, tcb_ptr_next;
    logic [31:0] rdata_next;
    logic [3:0] tcb_words;
    logic [5:0] tcb_cycles;
    logic halted;
    logic move;
    logic is_ext;
    logic done_evt;
    logic [1:0] pend;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    // descriptor size and load cost by transfer type
    function automatic logic [9:0] tcb_shape(input logic [2:0] ty);
        unique case (ty)
            3'h0: tcb_shape = {`TCB_WORDS_SERIAL, `TCB_CYCLES_SERIAL};
            3'h1: tcb_shape = {`TCB_WORDS_STD, `TCB_CYCLES_STD};
            3'h2: tcb_shape = {`TCB_WORDS_CIRC, `TCB_CYCLES_CIRC};
            3'h3: tcb_shape = {`TCB_WORDS_SG, `TCB_CYCLES_SG};
            default: tcb_shape = {`TCB_WORDS_CIRC_SG, `TCB_CYCLES_CIRC_SG};
        endcase
    endfunction : tcb_shape

    assign {tcb_words, tcb_cycles} = tcb_shape(ctrl_reg[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB]);
    assign is_ext = ctrl_reg[`CTRL_EXTERNAL];
    assign halted = i_emu_halt && ctrl_reg[`CTRL_HALT_STOP];
    // reads need two clocks per word, writes one
    assign move = (state_reg == dma_completion_pkg::ST_RUN) && !halted && i_xfer_req && !i_mem_busy
        && (count_reg != 32'h0) && (ctrl_reg[`CTRL_EXT_WRITE] || phase_reg);

    always_comb
    begin
        state_next = state_reg;
        ctrl_next = ctrl_reg;
        count_next = count_reg;
        index_next = index_reg;
        mod_next = mod_reg;
        chain_next = chain_reg;
        mask_next = mask_reg;
        prio_next = prio_reg;
        lcyc_next = lcyc_reg;
        lword_next = lword_reg;
        phase_next = phase_reg;
        tcb_ptr_next = tcb_ptr_reg;
        done_evt = 1'b0;
        if (state_reg == dma_completion_pkg::ST_RUN && !halted && i_xfer_req && !i_mem_busy)
        begin
            phase_next = !phase_reg;
        end
        unique case (state_reg)
            dma_completion_pkg::ST_IDLE:
            begin
                lcyc_next = 6'h0;
                lword_next = 4'h0;
            end
            dma_completion_pkg::ST_LOAD:
            begin
                if (!halted)
                begin
                    lcyc_next = lcyc_reg + 6'h1;
                    if (lcyc_reg[0] && lword_reg < tcb_words)
                    begin
                        lword_next = lword_reg + 4'h1;
                        unique case (lword_reg)
                            4'h0: index_next = i_mem_rdata;
                            4'h1: mod_next = i_mem_rdata;
                            4'h2: count_next = i_mem_rdata;
                            4'h3: chain_next = i_mem_rdata;
                            default: ;
                        endcase
                    end
                    if (lcyc_reg == tcb_cycles - 6'h1)
                    begin
                        state_next = dma_completion_pkg::ST_RUN;
                        phase_next = 1'b0;
                    end
                end
            end
            dma_completion_pkg::ST_RUN:
            begin
                if (move)
                begin
                    count_next = count_reg - 32'h1;
                    index_next = index_reg + mod_reg;
                    if (count_reg == 32'h1)
                    begin
                        state_next = dma_completion_pkg::ST_DRAIN;
                    end
                end
            end
            dma_completion_pkg::ST_DRAIN:
            begin
                // external writes, or internal writes of an external read, must settle
                if (!i_ext_pending && !i_mem_busy)
                begin
                    if (chain_reg[18:0] != 19'h0)
                    begin
                        done_evt = chain_reg[`CHAIN_PCI];
                        state_next = dma_completion_pkg::ST_LOAD;
                        tcb_ptr_next = chain_reg[18:0];
                        lcyc_next = 6'h0;
                        lword_next = 4'h0;
                    end
                    else
                    begin
                        done_evt = 1'b1;
                        state_next = dma_completion_pkg::ST_IDLE;
                        ctrl_next[`CTRL_ENABLE] = 1'b0;
                    end
                end
            end
            default: state_next = dma_completion_pkg::ST_IDLE;
        endcase
        if (i_wr)
        begin
            if (hit(i_addr, `REG_CTRL))
            begin
                ctrl_next = i_wdata[7:0];
                if (i_wdata[`CTRL_ENABLE] && state_reg == dma_completion_pkg::ST_IDLE)
                begin
                    state_next = dma_completion_pkg::ST_RUN;
                    phase_next = 1'b0;
                end
                else if (!i_wdata[`CTRL_ENABLE])
                begin
                    state_next = dma_completion_pkg::ST_IDLE;
                end
            end
            // zero just stops; one lets a single last word through
            if (hit(i_addr, `REG_COUNT))
            begin
                count_next = i_wdata;
                if (i_wdata == 32'h0 && state_reg == dma_completion_pkg::ST_RUN)
                begin
                    state_next = dma_completion_pkg::ST_IDLE;
                end
            end
            if (hit(i_addr, `REG_INDEX))
            begin
                index_next = i_wdata;
            end
            if (hit(i_addr, `REG_MODIFIER))
            begin
                mod_next = i_wdata;
            end
            if (hit(i_addr, `REG_CHAIN))
            begin
                chain_next = i_wdata;
                if (i_wdata[18:0] != 19'h0)
                begin
                    tcb_ptr_next = i_wdata[18:0];
                    state_next = dma_completion_pkg::ST_LOAD;
                    lcyc_next = 6'h0;
                    lword_next = 4'h0;
                end
            end
            if (hit(i_addr, `REG_MASK))
            begin
                mask_next = i_wdata[1:0];
            end
            if (hit(i_addr, `REG_PRIO))
            begin
                prio_next = i_wdata[1:0];
            end
        end
    end

    // latched events: set beats a write-one-to-clear in the same cycle
    always_comb
    begin
        latch_next = latch_reg;
        if (i_wr && hit(i_addr, `REG_LATCH))
        begin
            latch_next = latch_reg & ~i_wdata[1:0];
        end
        if (done_evt)
        begin
            latch_next[`IRQ_DONE] = 1'b1;
        end
        if (ctrl_reg[`CTRL_CORE_IRQ] && state_reg == dma_completion_pkg::ST_IDLE && (i_rx_avail || i_tx_room))
        begin
            latch_next[`IRQ_CORE] = 1'b1;
        end
    end

    always_comb
    begin
        rdata_next = 32'h0;
        if (i_rd)
        begin
            unique case (i_addr)
                `REG_CTRL: rdata_next = {24'h0, ctrl_reg};
                `REG_COUNT: rdata_next = count_reg;
                `REG_INDEX: rdata_next = index_reg;
                `REG_MODIFIER: rdata_next = mod_reg;
                `REG_CHAIN: rdata_next = chain_reg;
                `REG_STATUS: rdata_next = {28'h0, halted, state_reg};
                `REG_LATCH: rdata_next = {30'h0, latch_reg};
                `REG_MASK: rdata_next = {30'h0, mask_reg};
                `REG_PRIO: rdata_next = {30'h0, prio_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_reg <= dma_completion_pkg::ST_IDLE;
            ctrl_reg <= `CTRL_RESET;
            count_reg <= 32'h0;
            index_reg <= 32'h0;
            mod_reg <= 32'h0;
            chain_reg <= 32'h0;
            latch_reg <= 2'h0;
            mask_reg <= 2'h0;
            prio_reg <= `PRIO_RESET;
            lcyc_reg <= 6'h0;
            lword_reg <= 4'h0;
            phase_reg <= 1'b0;
            tcb_ptr_reg <= 19'h0;
            o_rdata <= 32'h0;
        end
        else
        begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            index_reg <= index_next;
            mod_reg <= mod_next;
            chain_reg <= chain_next;
            latch_reg <= latch_next;
            mask_reg <= mask_next;
            prio_reg <= prio_next;
            lcyc_reg <= lcyc_next;
            lword_reg <= lword_next;
            phase_reg <= phase_next;
            tcb_ptr_reg <= tcb_ptr_next;
            o_rdata <= rdata_next;
        end
    end

    assign pend = latch_reg & mask_reg;
    // slot k carries the source number held in prio_reg bit k
    assign o_irq_slot[0] = pend[prio_reg[0]];
    assign o_irq_slot[1] = pend[prio_reg[1]];
    assign o_bus_lock_periph = (state_reg == dma_completion_pkg::ST_LOAD) && !is_ext;
    assign o_bus_lock_ext = (state_reg == dma_completion_pkg::ST_LOAD) && is_ext;
    assign o_mem_addr = (state_reg == dma_completion_pkg::ST_LOAD)
        ? {13'h0, tcb_ptr_reg} + {28'h0, lword_reg} : index_reg;
    assign o_mem_rd = ((state_reg == dma_completion_pkg::ST_LOAD) && !halted && !lcyc_reg[0]
        && lword_reg < tcb_words) || (move && !ctrl_reg[`CTRL_EXT_WRITE]);
    assign o_mem_wr = move && ctrl_reg[`CTRL_EXT_WRITE];
    assign o_mem_wdata = 32'h0;
    assign o_xfer_ack = move;
    assign o_bkpt_hit = i_bkpt_en && (o_mem_rd || o_mem_wr) && (o_mem_addr == i_bkpt_addr);
endmodule : dma_completion_tcb_loader
`default_nettype wire
